// >>> vse_defines.vh
`ifndef VSE_DEFINES_VH
`define VSE_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define VSE_OFS_CTRL 8'h00
`define VSE_OFS_STATUS 8'h04
`define VSE_OFS_INT_CAUSE 8'h08
`define VSE_OFS_INT_MASK 8'h0C
`define VSE_OFS_LANE 8'h10
`define VSE_OFS_PHY 8'h14
`define VSE_OFS_MVID 8'h18
`define VSE_OFS_NVID 8'h1C
`define VSE_OFS_ATTR 8'h20
`define VSE_OFS_AUD_CTRL 8'h24
`define VSE_OFS_AUD_STATUS 8'h28
`define VSE_OFS_AUDIO_RATIO_MULT 8'h2C
`define VSE_OFS_AUDIO_RATIO_DIV 8'h30
`define VSE_OFS_BID 8'h34
`define VSE_OFS_AUD_RATE 8'h38
// Packet words: 0x40..0x5C info, 0x60..0x7C extension
`define VSE_PKT_REGION 2'h1
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define VSE_CTRL_TRAIN 1:0
`define VSE_CTRL_PPC 3:2
`define VSE_CTRL_HPD 4
`define VSE_CTRL_LANES 6:5
`define VSE_CTRL_GT32 7
`define VSE_CTRL_RATE 9:8
`define VSE_CTRL_W 10
`define VSE_CTRL_RESET 10'h000
`define VSE_PPC_2 2'h1
`define VSE_PPC_4 2'h2
`define VSE_RATE_162 2'h0
`define VSE_RATE_270 2'h1
`define VSE_EV_NOVID 0
`define VSE_EV_VBLANK 1
`define VSE_EV_MODE 2
`define VSE_EV_LOST 3
`define VSE_EV_INFO 4
`define VSE_EV_EXT 5
`define VSE_EV_W 6
`define VSE_MASK_RESET 6'h00
`define VSE_AUD_DISABLE 8'h00
`define VSE_AUD_ENABLE 8'h01
// Max audio sample rate in units of 0.1 kHz
`define VSE_FS_1920 16'h0780
`define VSE_FS_1764 16'h06E4
`define VSE_FS_960 16'h03C0
`define VSE_SYNC_W 247
`endif

// >>> vse_core.v
`timescale 1ns/1ps
`default_nettype none
`include "vse_defines.vh"
module vse_core (
    // System
    input wire CLOCK_I,
    input wire RESET_I,
    // Register port
    input wire [7:0] REG_ADDR_I,
    input wire [31:0] REG_WDATA_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    output reg [31:0] REG_RDATA_O,
    // Link receiver side, sampled on link clock edges except LINK_BID_I; LINK_VIDEO_I is also used as a level
    input wire LINK_CLK_I,
    input wire LINK_VIDEO_I,
    input wire LINK_VSYNC_I,
    input wire LINK_HSYNC_I,
    input wire LINK_DE_I,
    input wire [47:0] LINK_PIX_I,
    input wire [1:0] LINK_PATTERN_I,
    input wire [23:0] LINK_MVID_I,
    input wire [23:0] LINK_NVID_I,
    input wire [2:0] LINK_BPC_I,
    input wire [1:0] LINK_FMT_I,
    input wire LINK_AUD_VALID_I,
    input wire [2:0] LINK_AUD_CH_I,
    input wire [31:0] LINK_AUD_DATA_I,
    input wire LINK_PKT_VALID_I,
    input wire LINK_PKT_SOP_I,
    input wire LINK_PKT_EXT_I,
    input wire [31:0] LINK_PKT_DATA_I,
    input wire [23:0] LINK_AUDIO_RATIO_MULT_I,
    input wire [23:0] LINK_AUDIO_RATIO_DIV_I,
    input wire [7:0] LINK_BID_I,
    // PHY and cable status levels
    input wire CABLE_I,
    input wire TRAINED_I,
    input wire PLL_LOCK_I,
    input wire PHY_RST_DONE_I,
    input wire [3:0] LANE_ALIGN_I,
    input wire [3:0] SYM_LOCK_I,
    // User video
    output reg [191:0] VID_PIX_O,
    output reg VID_VALID_O,
    output reg VID_VSYNC_O,
    output reg VID_HSYNC_O,
    output reg [2:0] VID_BPC_O,
    output reg [1:0] VID_FMT_O,
    output wire VID_ATTR_VALID_O,
    // Clock regeneration ratios
    output reg [23:0] MVID_O,
    output reg [23:0] NVID_O,
    output reg MVID_UPDATE_O,
    output reg [23:0] AUDIO_RATIO_MULT_O,
    output reg [23:0] AUDIO_RATIO_DIV_O,
    // Audio stream, no ready input
    output reg [31:0] AUD_TDATA_O,
    output reg [7:0] AUD_TID_O,
    output reg AUD_TVALID_O,
    // Hot-plug and event line
    output wire HPD_O,
    output wire EVENT_IRQ_O
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Clock and data pass the same two stages so they stay aligned.
    wire [`VSE_SYNC_W-1:0] async_in;
    reg [`VSE_SYNC_W-1:0] sync_a;
    reg [`VSE_SYNC_W-1:0] s;
    reg lclk_q;
    assign async_in = {LINK_CLK_I, LINK_VIDEO_I, LINK_VSYNC_I, LINK_HSYNC_I,
        LINK_DE_I, LINK_PIX_I, LINK_PATTERN_I, LINK_MVID_I, LINK_NVID_I,
        LINK_BPC_I, LINK_FMT_I, LINK_AUD_VALID_I, LINK_AUD_CH_I,
        LINK_AUD_DATA_I, LINK_PKT_VALID_I, LINK_PKT_SOP_I, LINK_PKT_EXT_I,
        LINK_PKT_DATA_I, LINK_AUDIO_RATIO_MULT_I, LINK_AUDIO_RATIO_DIV_I, LINK_BID_I, CABLE_I,
        TRAINED_I, PLL_LOCK_I, PHY_RST_DONE_I, LANE_ALIGN_I, SYM_LOCK_I};
    always @(posedge CLOCK_I) begin
        sync_a <= async_in;
        s <= sync_a;
    end
    wire l_clk = s[246];
    wire l_video = s[245];
    wire l_vsync = s[244];
    wire l_hsync = s[243];
    wire l_de = s[242];
    wire [47:0] l_pix = s[241:194];
    wire [1:0] l_pattern = s[193:192];
    wire [23:0] l_mvid = s[191:168];
    wire [23:0] l_nvid = s[167:144];
    wire [2:0] l_bpc = s[143:141];
    wire [1:0] l_fmt = s[140:139];
    wire l_aud_valid = s[138];
    wire [2:0] l_aud_ch = s[137:135];
    wire [31:0] l_aud_data = s[134:103];
    wire l_pkt_valid = s[102];
    wire l_pkt_sop = s[101];
    wire l_pkt_ext = s[100];
    wire [31:0] l_pkt_data = s[99:68];
    wire [23:0] l_audio_ratio_mult = s[67:44];
    wire [23:0] l_audio_ratio_div = s[43:20];
    wire [7:0] l_bid = s[19:12];
    wire l_cable = s[11];
    wire l_trained = s[10];
    wire l_pll = s[9];
    wire l_rstdone = s[8];
    wire [3:0] l_align = s[7:4];
    wire [3:0] l_sym = s[3:0];
    wire ledge = l_clk & ~lclk_q;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [`VSE_CTRL_W-1:0] ctrl;
    reg [`VSE_EV_W-1:0] cause;
    reg [`VSE_EV_W-1:0] mask;
    reg aud_en;
    reg pattern_seen;
    reg video_q;
    reg link_up_q;
    reg cable_q;
    reg absent;
    reg hpd_auto;
    wire wr = REG_WR_I;
    wire [1:0] train_mode = ctrl[`VSE_CTRL_TRAIN];
    wire training = train_mode != 2'h0;
    wire link_up = l_cable & l_trained;
    // Cable returning restarts the datapath without software help
    wire self_rst = l_cable & ~cable_q;
    wire dp_rst = RESET_I | self_rst;
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ctrl <= `VSE_CTRL_RESET;
            mask <= `VSE_MASK_RESET;
            aud_en <= 1'b0;
        end else if (wr) begin
            if (REG_ADDR_I == `VSE_OFS_CTRL)
                ctrl <= REG_WDATA_I[`VSE_CTRL_W-1:0];
            if (REG_ADDR_I == `VSE_OFS_INT_MASK)
                mask <= REG_WDATA_I[`VSE_EV_W-1:0];
            if (REG_ADDR_I == `VSE_OFS_AUD_CTRL) begin
                if (REG_WDATA_I[7:0] == `VSE_AUD_ENABLE)
                    aud_en <= 1'b1;
                else if (REG_WDATA_I[7:0] == `VSE_AUD_DISABLE)
                    aud_en <= 1'b0;
            end
        end
    end
    wire aud_flush = wr & (REG_ADDR_I == `VSE_OFS_AUD_CTRL)
        & (REG_WDATA_I[7:0] == `VSE_AUD_DISABLE);

    // ----------------------------------------
    // Training pattern and hot-plug
    // ----------------------------------------
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            lclk_q <= 1'b0;
            pattern_seen <= 1'b0;
            video_q <= 1'b0;
            link_up_q <= 1'b0;
            cable_q <= 1'b0;
            absent <= 1'b0;
            hpd_auto <= 1'b0;
        end else begin
            lclk_q <= l_clk;
            video_q <= l_video;
            link_up_q <= link_up;
            cable_q <= l_cable;
            if (!training)
                pattern_seen <= 1'b0;
            else if (ledge && l_pattern == train_mode)
                pattern_seen <= 1'b1;
            if (self_rst)
                hpd_auto <= 1'b1;
            else if (!l_cable)
                hpd_auto <= 1'b0;
            if (video_q && !l_video)
                absent <= 1'b1;
            else if (l_video)
                absent <= 1'b0;
        end
    end
    // Software may also raise hot-plug to ask for retraining
    assign HPD_O = hpd_auto | ctrl[`VSE_CTRL_HPD];
    // Attributes are only meaningful with video on a live link
    assign VID_ATTR_VALID_O = l_video & link_up;

    // ----------------------------------------
    // Events
    // ----------------------------------------
    reg [`VSE_EV_W-1:0] ev;
    reg fmt_change;
    reg info_done;
    reg ext_done;
    always @* begin
        ev = {`VSE_EV_W{1'b0}};
        ev[`VSE_EV_NOVID] = video_q & ~l_video;
        ev[`VSE_EV_VBLANK] = absent & l_video;
        ev[`VSE_EV_MODE] = fmt_change;
        ev[`VSE_EV_LOST] = link_up_q & ~link_up;
        ev[`VSE_EV_INFO] = info_done;
        ev[`VSE_EV_EXT] = ext_done;
    end
    wire [`VSE_EV_W-1:0] ev_clr = (wr && REG_ADDR_I == `VSE_OFS_INT_CAUSE) ?
        REG_WDATA_I[`VSE_EV_W-1:0] : {`VSE_EV_W{1'b0}};
    always @(posedge CLOCK_I) begin
        if (RESET_I)
            cause <= {`VSE_EV_W{1'b0}};
        else
            cause <= (cause & ~ev_clr) | ev;
    end
    assign EVENT_IRQ_O = |(cause & mask);

    // ----------------------------------------
    // Video datapath
    // ----------------------------------------
    reg [1:0] pix_cnt;
    reg [191:0] pix_acc;
    wire [1:0] ppc = ctrl[`VSE_CTRL_PPC];
    wire [1:0] pix_last = (ppc == `VSE_PPC_4) ? 2'h3 :
        (ppc == `VSE_PPC_2) ? 2'h1 : 2'h0;
    // Training holds the datapath closed
    wire pix_take = ledge & l_de & l_video & ~training;
    reg [191:0] next_acc;
    always @* begin
        next_acc = pix_acc;
        next_acc[48*pix_cnt +: 48] = l_pix;
    end
    always @(posedge CLOCK_I) begin
        if (dp_rst) begin
            pix_cnt <= 2'h0;
            pix_acc <= 192'h0;
            VID_PIX_O <= 192'h0;
            VID_VALID_O <= 1'b0;
            VID_VSYNC_O <= 1'b0;
            VID_HSYNC_O <= 1'b0;
        end else begin
            VID_VALID_O <= 1'b0;
            if (ledge && !training) begin
                VID_VSYNC_O <= l_vsync;
                VID_HSYNC_O <= l_hsync;
            end
            if (pix_take) begin
                if (pix_cnt == pix_last) begin
                    VID_PIX_O <= next_acc;
                    VID_VALID_O <= 1'b1;
                    pix_cnt <= 2'h0;
                    pix_acc <= 192'h0;
                end else begin
                    pix_acc <= next_acc;
                    pix_cnt <= pix_cnt + 2'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Stream attributes and ratios
    // ----------------------------------------
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            VID_BPC_O <= 3'h0;
            VID_FMT_O <= 2'h0;
            MVID_O <= 24'h0;
            NVID_O <= 24'h0;
            MVID_UPDATE_O <= 1'b0;
            AUDIO_RATIO_MULT_O <= 24'h0;
            AUDIO_RATIO_DIV_O <= 24'h0;
            fmt_change <= 1'b0;
        end else begin
            MVID_UPDATE_O <= 1'b0;
            fmt_change <= 1'b0;
            if (ledge && l_video) begin
                VID_BPC_O <= l_bpc;
                VID_FMT_O <= l_fmt;
                fmt_change <= (l_bpc != VID_BPC_O) | (l_fmt != VID_FMT_O);
                MVID_O <= l_mvid;
                NVID_O <= l_nvid;
                MVID_UPDATE_O <= (l_mvid != MVID_O) | (l_nvid != NVID_O);
            end
            if (ledge) begin
                AUDIO_RATIO_MULT_O <= l_audio_ratio_mult;
                AUDIO_RATIO_DIV_O <= l_audio_ratio_div;
            end
        end
    end

    // ----------------------------------------
    // Info and extension packet buffers
    // ----------------------------------------
    reg [31:0] pkt_mem [0:15];
    reg info_full;
    reg ext_full;
    reg cap_on;
    reg cap_ext;
    reg [2:0] cap_idx;
    reg [3:0] stream_id;
    reg [2:0] ch_max;
    reg [7:0] spk_alloc;
    wire pkt_rd = REG_RD_I & (REG_ADDR_I[7:6] == `VSE_PKT_REGION);
    wire rd_last = pkt_rd & (REG_ADDR_I[4:2] == 3'h7);
    wire buf_busy = l_pkt_ext ? ext_full : info_full;
    wire pkt_take = ledge & l_pkt_valid;
    always @(posedge CLOCK_I) begin
        if (dp_rst | aud_flush) begin
            info_full <= 1'b0;
            ext_full <= 1'b0;
            cap_on <= 1'b0;
            cap_ext <= 1'b0;
            cap_idx <= 3'h0;
            info_done <= 1'b0;
            ext_done <= 1'b0;
            stream_id <= 4'h0;
            ch_max <= 3'h7;
            spk_alloc <= 8'hFF;
        end else begin
            info_done <= 1'b0;
            ext_done <= 1'b0;
            // Reading the last word frees the buffer for the next packet
            if (rd_last && !REG_ADDR_I[5])
                info_full <= 1'b0;
            if (rd_last && REG_ADDR_I[5])
                ext_full <= 1'b0;
            if (pkt_take && l_pkt_sop) begin
                // A packet arriving at a full buffer is dropped whole
                cap_on <= ~buf_busy;
                cap_ext <= l_pkt_ext;
                cap_idx <= 3'h1;
                if (!buf_busy) begin
                    pkt_mem[{l_pkt_ext, 3'h0}] <= l_pkt_data;
                    if (!l_pkt_ext) begin
                        stream_id <= l_pkt_data[3:0];
                        ch_max <= l_pkt_data[6:4];
                        spk_alloc <= l_pkt_data[15:8];
                    end
                end
            end else if (pkt_take && cap_on) begin
                pkt_mem[{cap_ext, cap_idx}] <= l_pkt_data;
                cap_idx <= cap_idx + 3'h1;
                if (cap_idx == 3'h7) begin
                    cap_on <= 1'b0;
                    if (cap_ext) begin
                        ext_full <= 1'b1;
                        ext_done <= 1'b1;
                    end else begin
                        info_full <= 1'b1;
                        info_done <= 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Audio stream output
    // ----------------------------------------
    // No ready input: a sample is shown for one cycle and never held.
    wire ch_ok = spk_alloc[l_aud_ch] & (l_aud_ch <= ch_max);
    always @(posedge CLOCK_I) begin
        if (dp_rst | aud_flush) begin
            AUD_TDATA_O <= 32'h0;
            AUD_TID_O <= 8'h0;
            AUD_TVALID_O <= 1'b0;
        end else begin
            AUD_TVALID_O <= 1'b0;
            if (ledge && l_aud_valid && aud_en && ch_ok) begin
                AUD_TDATA_O <= l_aud_data;
                AUD_TID_O <= {stream_id, 1'b0, l_aud_ch};
                AUD_TVALID_O <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    reg [15:0] fs_max;
    reg [3:0] lane_on;
    always @* begin
        case (ctrl[`VSE_CTRL_LANES])
            2'h0: lane_on = 4'h1;
            2'h1: lane_on = 4'h3;
            default: lane_on = 4'hF;
        endcase
        if (!ctrl[`VSE_CTRL_GT32])
            fs_max = `VSE_FS_1920;
        else if (ctrl[`VSE_CTRL_RATE] == `VSE_RATE_162)
            fs_max = `VSE_FS_960;
        else if (ctrl[`VSE_CTRL_RATE] == `VSE_RATE_270)
            fs_max = `VSE_FS_1764;
        else
            fs_max = `VSE_FS_1920;
    end
    always @(posedge CLOCK_I) begin
        if (RESET_I) begin
            REG_RDATA_O <= 32'h0;
        end else if (REG_RD_I) begin
            if (REG_ADDR_I[7:6] == `VSE_PKT_REGION)
                REG_RDATA_O <= pkt_mem[REG_ADDR_I[5:2]];
            else begin
                case (REG_ADDR_I)
                    `VSE_OFS_CTRL: REG_RDATA_O <= {22'h0, ctrl};
                    `VSE_OFS_STATUS: REG_RDATA_O <= {27'h0, HPD_O, l_cable,
                        l_trained, l_video, pattern_seen};
                    `VSE_OFS_INT_CAUSE: REG_RDATA_O <= {26'h0, cause};
                    `VSE_OFS_INT_MASK: REG_RDATA_O <= {26'h0, mask};
                    `VSE_OFS_LANE: REG_RDATA_O <= {24'h0, l_sym & lane_on,
                        l_align & lane_on};
                    `VSE_OFS_PHY: REG_RDATA_O <= {30'h0, l_rstdone,
                        l_pll};
                    `VSE_OFS_MVID: REG_RDATA_O <= {8'h0, MVID_O};
                    `VSE_OFS_NVID: REG_RDATA_O <= {8'h0, NVID_O};
                    `VSE_OFS_ATTR: REG_RDATA_O <= {27'h0, VID_FMT_O, VID_BPC_O};
                    `VSE_OFS_AUD_CTRL: REG_RDATA_O <= {31'h0, aud_en};
                    `VSE_OFS_AUD_STATUS: REG_RDATA_O <= {30'h0, ext_full,
                        info_full};
                    `VSE_OFS_AUDIO_RATIO_MULT: REG_RDATA_O <= {8'h0, AUDIO_RATIO_MULT_O};
                    `VSE_OFS_AUDIO_RATIO_DIV: REG_RDATA_O <= {8'h0, AUDIO_RATIO_DIV_O};
                    `VSE_OFS_BID: REG_RDATA_O <= {24'h0, l_bid};
                    `VSE_OFS_AUD_RATE: REG_RDATA_O <= {16'h0, fs_max};
                    default: REG_RDATA_O <= 32'h0;
                endcase
            end
        end
    end
endmodule // vse_core
`default_nettype wire

// >>> vse_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vse_core_properties (
    // Clock, reset and register port
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    // Watched outputs
    input wire logic VID_VALID_O,
    input wire logic VID_ATTR_VALID_O,
    input wire logic [23:0] MVID_O,
    input wire logic [23:0] NVID_O,
    input wire logic MVID_UPDATE_O,
    input wire logic [23:0] AUDIO_RATIO_MULT_O,
    input wire logic [7:0] AUD_TID_O,
    input wire logic AUD_TVALID_O,
    input wire logic HPD_O,
    input wire logic EVENT_IRQ_O
);
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (RESET_I);
    // A sample launched before the write cycle may still show in it; six quiet cycles cover it
    sequence s_aud_off;
        REG_WR_I && REG_ADDR_I == 8'h24 && REG_WDATA_I == 32'h0
            ##1 !(REG_WR_I && REG_ADDR_I == 8'h24) [*6];
    endsequence
    sequence s_rd(logic [7:0] a);
        REG_RD_I && REG_ADDR_I == a;
    endsequence
    chk_vid_pulse: assert property (VID_VALID_O |=> !VID_VALID_O)
        else $error("video valid longer than one cycle");
    chk_aud_tag: assert property (AUD_TVALID_O |-> !AUD_TID_O[3] ##1 !AUD_TVALID_O)
        else $error("audio tag or pulse wrong");
    chk_update_flag: assert property ($changed(MVID_O) || $changed(NVID_O) |-> ##[0:1] MVID_UPDATE_O)
        else $error("ratio change without update pulse");
    chk_novid_quiet: assert property (!VID_ATTR_VALID_O [*4] |-> !VID_VALID_O)
        else $error("video out while absent");
    chk_irq_masked: assert property (REG_WR_I && REG_ADDR_I == 8'h0C && REG_WDATA_I[5:0] == 6'h00 |=> !EVENT_IRQ_O)
        else $error("event line high with all masked");
    chk_hpd_soft: assert property (REG_WR_I && REG_ADDR_I == 8'h00 && REG_WDATA_I[4] |=> HPD_O)
        else $error("software hot-plug not seen");
    chk_aud_flush: assert property (s_aud_off |-> !AUD_TVALID_O)
        else $error("audio sample after disable");
    chk_audio_ratio_mult_read: assert property (s_rd(8'h2C) |=> REG_RDATA_O[23:0] == $past(AUDIO_RATIO_MULT_O))
        else $error("audio ratio register differs from port");
    chk_mvid_read: assert property (s_rd(8'h18) |=> REG_RDATA_O[23:0] == $past(MVID_O))
        else $error("video ratio register differs from port");
endmodule // vse_core_properties
bind vse_core vse_core_properties u_vse_core_properties (.*);
`default_nettype wire

// >>> vse_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module vse_source_model (
    // Link beat outputs
    output logic link_clk_o,
    output logic de_o,
    output logic [47:0] pix_o,
    output logic aud_valid_o,
    output logic [2:0] aud_ch_o,
    output logic [31:0] aud_data_o,
    output logic pkt_valid_o,
    output logic pkt_sop_o,
    output logic pkt_ext_o,
    output logic [31:0] pkt_data_o
);
    initial begin
        link_clk_o = 1'b0;
        de_o = 1'b0;
        pix_o = 48'h0;
        aud_valid_o = 1'b0;
        aud_ch_o = 3'h0;
        aud_data_o = 32'h0;
        pkt_valid_o = 1'b0;
        pkt_sop_o = 1'b0;
        pkt_ext_o = 1'b0;
        pkt_data_o = 32'h0;
    end
    // One 80 ns link period; the clock stands still between beats
    task automatic beat();
        #37 link_clk_o = 1'b1;
        #40 link_clk_o = 1'b0;
        #3 de_o = 1'b0;
        // Released data buses show the inverse; aud_ch_o and pkt_ext_o keep the stale value
        pix_o = ~pix_o;
        aud_valid_o = 1'b0;
        aud_data_o = ~aud_data_o;
        pkt_valid_o = 1'b0;
        pkt_sop_o = 1'b0;
        pkt_data_o = ~pkt_data_o;
    endtask
    task automatic pix(input logic [47:0] p);
        de_o = 1'b1;
        pix_o = p;
        beat();
    endtask
    task automatic aud(input logic [2:0] ch, input logic [31:0] d);
        aud_valid_o = 1'b1;
        aud_ch_o = ch;
        aud_data_o = d;
        beat();
    endtask
    task automatic pkt(input logic ext, input logic [31:0] base);
        for (int i = 0; i < 8; i++) begin
            pkt_valid_o = 1'b1;
            pkt_sop_o = (i == 0);
            pkt_ext_o = ext;
            pkt_data_o = base + 32'(i);
            beat();
        end
    endtask
endmodule // vse_source_model
`default_nettype wire

// >>> vse_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vse_core_tb_top;
    logic CLOCK_I, RESET_I, REG_WR_I = 1'b0, REG_RD_I = 1'b0, LINK_CLK_I, LINK_DE_I;
    logic LINK_VIDEO_I = 1'b1, LINK_VSYNC_I = 1'b0, LINK_HSYNC_I = 1'b0, CABLE_I = 1'b1;
    logic TRAINED_I = 1'b1, PLL_LOCK_I = 1'b1, PHY_RST_DONE_I = 1'b1;
    logic LINK_AUD_VALID_I, LINK_PKT_VALID_I, LINK_PKT_SOP_I, LINK_PKT_EXT_I, VID_VALID_O;
    logic VID_VSYNC_O, VID_HSYNC_O, VID_ATTR_VALID_O, MVID_UPDATE_O, AUD_TVALID_O, HPD_O;
    logic EVENT_IRQ_O;
    logic [1:0] LINK_PATTERN_I = 2'h0, LINK_FMT_I = 2'h0, VID_FMT_O;
    logic [2:0] LINK_BPC_I = 3'h1, LINK_AUD_CH_I, VID_BPC_O;
    logic [3:0] LANE_ALIGN_I = 4'hF, SYM_LOCK_I = 4'h5;
    logic [7:0] REG_ADDR_I = 8'h00, LINK_BID_I = 8'h00, AUD_TID_O, last_tid;
    logic [23:0] LINK_MVID_I = 24'h0, LINK_NVID_I = 24'h0, LINK_AUDIO_RATIO_MULT_I = 24'h0;
    logic [23:0] LINK_AUDIO_RATIO_DIV_I = 24'h0, MVID_O, NVID_O, AUDIO_RATIO_MULT_O, AUDIO_RATIO_DIV_O;
    logic [31:0] REG_WDATA_I = 32'h0, REG_RDATA_O, LINK_AUD_DATA_I, LINK_PKT_DATA_I;
    logic [31:0] AUD_TDATA_O, rv, last_dat;
    logic [47:0] LINK_PIX_I;
    logic [191:0] VID_PIX_O, last_pix;
    int n_errors, checked, n_vid, n_aud, n_upd;
    vse_core u_vse_core (.*);
    vse_source_model u_vse_source_model (.link_clk_o(LINK_CLK_I), .de_o(LINK_DE_I),
        .pix_o(LINK_PIX_I), .aud_valid_o(LINK_AUD_VALID_I), .aud_ch_o(LINK_AUD_CH_I),
        .aud_data_o(LINK_AUD_DATA_I), .pkt_valid_o(LINK_PKT_VALID_I),
        .pkt_sop_o(LINK_PKT_SOP_I), .pkt_ext_o(LINK_PKT_EXT_I), .pkt_data_o(LINK_PKT_DATA_I));
    initial begin
        CLOCK_I = 1'b0;
        forever #5 CLOCK_I = ~CLOCK_I;
    end
    // -------------------------------------------
    // Pulse catcher; no ready exists, so the audio side is never held off
    // -------------------------------------------
    always @(posedge CLOCK_I) begin
        if (VID_VALID_O === 1'b1) begin
            n_vid <= n_vid + 1;
            last_pix <= VID_PIX_O;
        end
        if (AUD_TVALID_O === 1'b1) begin
            n_aud <= n_aud + 1;
            last_tid <= AUD_TID_O;
            last_dat <= AUD_TDATA_O;
        end
        if (MVID_UPDATE_O === 1'b1) begin
            n_upd <= n_upd + 1;
        end
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge CLOCK_I);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= a;
        REG_WDATA_I <= d;
        @(posedge CLOCK_I);
        REG_WR_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLOCK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge CLOCK_I);
        REG_RD_I <= 1'b0;
        #1 rv = REG_RDATA_O;
    endtask
    task automatic t_status();
        wr(8'h00, 32'h20);
        rd(8'h38); chk(rv, 32'h780);
        rd(8'h14); chk(rv, 32'h3);
        rd(8'h10); chk(rv, 32'h13);
        rd(8'h3C); chk(rv, 32'h0);
        wr(8'h00, 32'h80);
        rd(8'h38); chk(rv, 32'h3C0);
        wr(8'h00, 32'h180);
        rd(8'h38); chk(rv, 32'h6E4);
    endtask
    task automatic t_video();
        int v;
        for (int c = 0; c < 3; c++) begin
            wr(8'h00, {28'h0, c[1:0], 2'h0});
            v = n_vid;
            for (int k = 0; k < (1 << c); k++) begin
                u_vse_source_model.pix(48'hC0DE_0000_0000 + 48'(16 * c + k));
            end
            wt(6);
            chk(n_vid - v, 1);
            for (int k = 0; k < (1 << c); k++) begin
                chk(last_pix[48 * k +: 48], 48'hC0DE_0000_0000 + 48'(16 * c + k));
            end
        end
        wr(8'h00, 32'h1);
        LINK_PATTERN_I <= 2'h1;
        v = n_vid;
        u_vse_source_model.pix(48'h1);
        wt(6);
        chk(n_vid - v, 0);
        rd(8'h04); chk(rv[0], 1'b1);
        wr(8'h00, 32'h0);
        LINK_PATTERN_I <= 2'h0;
        v = n_upd;
        LINK_MVID_I <= 24'h12345;
        LINK_NVID_I <= 24'h8000;
        u_vse_source_model.beat();
        wt(6);
        chk(n_upd - v, 1);
        chk(NVID_O, 24'h8000);
        rd(8'h18); chk(rv, 32'h12345);
    endtask
    task automatic t_events();
        wr(8'h0C, 32'h3F);
        wr(8'h08, 32'h3F);
        LINK_VIDEO_I <= 1'b0;
        u_vse_source_model.beat();
        wt(6);
        chk(VID_ATTR_VALID_O, 1'b0);
        rd(8'h08); chk(rv, 32'h1);
        wr(8'h08, 32'h3F);
        LINK_VIDEO_I <= 1'b1;
        u_vse_source_model.beat();
        wt(6);
        rd(8'h08); chk(rv, 32'h2);
        wr(8'h08, 32'h3F);
        LINK_BPC_I <= 3'h2;
        LINK_FMT_I <= 2'h1;
        LINK_VSYNC_I <= 1'b1;
        LINK_HSYNC_I <= 1'b1;
        u_vse_source_model.beat();
        wt(6);
        rd(8'h08); chk(rv, 32'h4);
        rd(8'h20); chk(rv, 32'h0A);
        chk(VID_BPC_O, 3'h2);
        chk(VID_FMT_O, 2'h1);
        chk(VID_VSYNC_O, 1'b1);
        chk(VID_HSYNC_O, 1'b1);
        wr(8'h08, 32'h3F);
        TRAINED_I <= 1'b0;
        wt(6);
        rd(8'h08); chk(rv, 32'h8);
        chk(EVENT_IRQ_O, 1'b1);
        wr(8'h0C, 32'h0);
        wt(1);
        chk(EVENT_IRQ_O, 1'b0);
        TRAINED_I <= 1'b1;
        CABLE_I <= 1'b0;
        wt(6);
        chk(HPD_O, 1'b0);
        wr(8'h00, 32'h10);
        wt(1);
        chk(HPD_O, 1'b1);
        wr(8'h00, 32'h0);
        CABLE_I <= 1'b1;
        wt(6);
        chk(HPD_O, 1'b1);
    endtask
    task automatic t_audio();
        int v;
        wr(8'h0C, 32'h30);
        wr(8'h08, 32'h3F);
        wr(8'h24, 32'h1);
        u_vse_source_model.pkt(1'b0, 32'h0F75);
        wt(6);
        rd(8'h28); chk(rv, 32'h1);
        rd(8'h08); chk(rv, 32'h10);
        chk(EVENT_IRQ_O, 1'b1);
        u_vse_source_model.pkt(1'b0, 32'h0E00);
        wt(6);
        rd(8'h40); chk(rv, 32'h0F75);
        rd(8'h5C); chk(rv, 32'h0F7C);
        rd(8'h28); chk(rv, 32'h0);
        u_vse_source_model.pkt(1'b1, 32'hE0);
        wt(6);
        rd(8'h28); chk(rv, 32'h2);
        rd(8'h08); chk(rv, 32'h30);
        v = n_aud;
        u_vse_source_model.aud(3'h2, 32'hA5A5_0002);
        wt(6);
        chk(n_aud - v, 1);
        chk(last_tid, 8'h52);
        chk(last_dat, 32'hA5A5_0002);
        u_vse_source_model.aud(3'h5, 32'h5);
        wt(6);
        chk(n_aud - v, 1);
        wr(8'h24, 32'h0);
        u_vse_source_model.aud(3'h2, 32'h7);
        wt(6);
        chk(n_aud - v, 1);
        rd(8'h28); chk(rv, 32'h0);
        LINK_AUDIO_RATIO_MULT_I <= 24'hABCD;
        LINK_BID_I <= 8'h10;
        LINK_AUDIO_RATIO_DIV_I <= 24'h8000;
        u_vse_source_model.beat();
        wt(6);
        chk(AUDIO_RATIO_DIV_O, 24'h8000);
        rd(8'h2C); chk(rv, 32'hABCD);
        rd(8'h34); chk(rv, 32'h10);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        RESET_I = 1'b1;
        wt(10);
        RESET_I <= 1'b0;
        t_status();
        t_video();
        t_events();
        t_audio();
        wrap_up();
    end
    // About 40 link beats and 210 register cycles are expected; allow ample margin
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule // vse_core_tb_top
`default_nettype wire
